// ===== verif/ebl_ee_model.sv
// Behavioural serial EEPROM seen over SPI mode 3 or through a byte-level I2C engine.
`timescale 1ns/1ns
`default_nettype none
module ebl_ee_model (
  input  wire logic        mclk_i,  // Core clock
  input  wire logic        sclk_i,  // SPI clock
  input  wire logic        mosi_i,  // SPI data in
  input  wire logic        ss_b_i,  // SPI select, active low
  output var  logic        miso_o,  // SPI data out
  input  wire logic        start_i, // I2C read open
  input  wire logic [6:0]  chip_i,  // I2C chip address
  input  wire logic [23:0] addr_i,  // I2C start address
  input  wire logic        get_i,   // I2C byte request
  output var  logic        rdy_o,   // I2C ready
  output var  logic [7:0]  byte_o,  // I2C byte
  output var  logic        vld_o    // I2C byte valid
);
  logic [7:0]  mem [0:255];
  logic [31:0] cmd;
  logic [23:0] ptr;
  logic        mine;
  int          cnt;
  int          wait_n;
  initial begin
    miso_o = 1'b1; rdy_o = 1'b1; byte_o = 8'h00; vld_o = 1'b0;
    cmd = 32'h0; ptr = 24'h0; mine = 1'b0; cnt = 0; wait_n = 0;
  end
  // Odd addresses answer one cycle later so both latencies are exercised.
  always @(negedge mclk_i) begin
    vld_o = 1'b0;
    byte_o = ~byte_o;
    if (ss_b_i) miso_o = ~miso_o;
    if (start_i) begin
      ptr = addr_i;
      mine = (chip_i == 7'h50);
    end
    if (wait_n > 0) begin
      wait_n--;
      if (wait_n == 0) begin
        vld_o = 1'b1;
        byte_o = mine ? mem[ptr[7:0]] : ~mem[ptr[7:0]];
        ptr = ptr + 24'h1;
      end
    end else if (get_i) wait_n = 1 + ptr[0];
  end
  always @(negedge ss_b_i) cnt = 0;
  always @(posedge sclk_i) begin
    if (!ss_b_i) begin
      if (cnt < 32) cmd = {cmd[30:0], mosi_i};
      else if (cnt % 8 == 7) ptr = ptr + 24'h1;
      cnt++;
      if (cnt == 32) ptr = cmd[23:0];
    end
  end
  always @(negedge sclk_i) begin
    if (!ss_b_i && cnt >= 32)
      miso_o = (cmd[31:24] == 8'h03) ? mem[ptr[7:0]][7 - (cnt % 8)] : ~miso_o;
  end
endmodule // ebl_ee_model
`default_nettype wire

// ===== verif/ebl_loader_properties.sv
// Concurrent checks on the ports of the boot image loader.
`timescale 1ns/1ns
`default_nettype none
module ebl_loader_chk (
  input wire logic        mclk_i,       // Core clock
  input wire logic        rst_b_i,      // Sync reset, active low
  input wire logic        boot_start_i, // Boot request
  input wire logic        spi_sclk_o,   // SPI clock
  input wire logic        spi_ss_b_o,   // SPI select
  input wire logic        i2c_start_o,  // I2C read open
  input wire logic [6:0]  i2c_chip_o,   // I2C chip address
  input wire logic        mem_we_o,     // Memory write
  input wire logic [2:0]  mem_sel_o,    // Memory select
  input wire logic [15:0] mem_addr_o,   // Memory address
  input wire logic [31:0] mem_wdata_o,  // Memory data
  input wire logic        mem_ack_i,    // Memory accept
  input wire logic        busy_o,       // Boot running
  input wire logic        boot_done_o,  // Boot finished
  input wire logic        panic_o,      // Final panic
  input wire logic        sleep_o       // Core asleep
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  sequence s_wr_wait; mem_we_o && !mem_ack_i; endsequence
  sequence s_wr_take; mem_we_o && mem_ack_i; endsequence
  chip_fixed_a: assert property (i2c_start_o |-> i2c_chip_o == 7'h50)
    else $error("I2C read opened on a foreign chip address");
  sel_onehot_a: assert property (mem_we_o |-> mem_sel_o inside {3'h1, 3'h2, 3'h4})
    else $error("Memory select is not a legal target");
  wr_hold_a: assert property (s_wr_wait |=> mem_we_o && $stable(mem_addr_o)
    && $stable(mem_wdata_o) && $stable(mem_sel_o)) else $error("Write dropped or changed");
  wr_drop_a: assert property (s_wr_take |=> !mem_we_o)
    else $error("Write still raised after accept");
  ss_idle_a: assert property (!busy_o |-> spi_ss_b_o)
    else $error("SPI select low while idle");
  sclk_idle_a: assert property (spi_ss_b_o |-> spi_sclk_o)
    else $error("SPI clock low while deselected");
  i2c_no_ss_a: assert property (i2c_start_o |-> spi_ss_b_o)
    else $error("SPI selected during an I2C boot");
  done_clean_a: assert property (boot_done_o |-> !panic_o && !busy_o)
    else $error("Done together with panic or busy");
  panic_sleep_a: assert property (panic_o |-> sleep_o && !busy_o)
    else $error("Panic without sleep");
  done_rise_a: assert property ($rose(boot_done_o) |-> $past(busy_o))
    else $error("Done rose without a boot");
  start_clear_a: assert property (boot_start_i && !busy_o |=> busy_o && !boot_done_o
    && !panic_o) else $error("Accepted start did not clear status");
endmodule // ebl_loader_chk

bind ebl_loader ebl_loader_chk u_chk (
  .mclk_i(mclk_i), .rst_b_i(rst_b_i), .boot_start_i(boot_start_i), .spi_sclk_o(spi_sclk_o),
  .spi_ss_b_o(spi_ss_b_o), .i2c_start_o(i2c_start_o), .i2c_chip_o(i2c_chip_o),
  .mem_we_o(mem_we_o), .mem_sel_o(mem_sel_o), .mem_addr_o(mem_addr_o),
  .mem_wdata_o(mem_wdata_o), .mem_ack_i(mem_ack_i), .busy_o(busy_o),
  .boot_done_o(boot_done_o), .panic_o(panic_o), .sleep_o(sleep_o));
`default_nettype wire

// ===== verif/ebl_loader_tb_top.sv
// Self-checking bench for the boot image loader over both EEPROM links.
`timescale 1ns/1ns
`default_nettype none
module ebl_loader_tb_top;
  logic        mclk_i = 1'b0, rst_b_i = 1'b0, boot_start_i = 1'b0, use_i2c_i = 1'b0;
  logic        mem_ack_i = 1'b0, ack_w = 1'b0, spi_miso_i, i2c_rdy_i, i2c_vld_i;
  logic        spi_sclk_o, spi_mosi_o, spi_ss_b_o, i2c_start_o, i2c_stop_o, i2c_get_o;
  logic        mem_we_o, busy_o, boot_done_o, fail_o, panic_o, sleep_o;
  logic [6:0]  i2c_chip_o;
  logic [23:0] i2c_addr_o;
  logic [7:0]  i2c_byte_i, pll_div_o, pll_feedback_divider_o, mclk_out_o;
  logic [2:0]  mem_sel_o, panic_code_o;
  logic [15:0] mem_addr_o, jump_addr_o;
  logic [31:0] mem_wdata_o, speed_cfg_o;
  logic [50:0] wr [0:15];
  logic [63:0] sum;
  int          failures = 0, num_checks = 0, nwr = 0, nfail = 0, nstop = 0;

  ebl_loader u_dut (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .boot_start_i(boot_start_i),
    .use_i2c_i(use_i2c_i), .spi_sclk_o(spi_sclk_o), .spi_mosi_o(spi_mosi_o),
    .spi_ss_b_o(spi_ss_b_o), .spi_miso_i(spi_miso_i), .i2c_start_o(i2c_start_o),
    .i2c_stop_o(i2c_stop_o), .i2c_chip_o(i2c_chip_o), .i2c_addr_o(i2c_addr_o),
    .i2c_get_o(i2c_get_o), .i2c_rdy_i(i2c_rdy_i), .i2c_byte_i(i2c_byte_i),
    .i2c_vld_i(i2c_vld_i), .mem_we_o(mem_we_o), .mem_sel_o(mem_sel_o),
    .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .mem_ack_i(mem_ack_i),
    .pll_div_o(pll_div_o), .pll_feedback_divider_o(pll_feedback_divider_o),
    .mclk_out_o(mclk_out_o), .speed_cfg_o(speed_cfg_o), .jump_addr_o(jump_addr_o),
    .busy_o(busy_o), .boot_done_o(boot_done_o), .fail_o(fail_o),
    .panic_code_o(panic_code_o), .panic_o(panic_o), .sleep_o(sleep_o));
  ebl_ee_model u_ee (.mclk_i(mclk_i), .sclk_i(spi_sclk_o), .mosi_i(spi_mosi_o),
    .ss_b_i(spi_ss_b_o), .miso_o(spi_miso_i), .start_i(i2c_start_o), .chip_i(i2c_chip_o),
    .addr_i(i2c_addr_o), .get_i(i2c_get_o), .rdy_o(i2c_rdy_i), .byte_o(i2c_byte_i),
    .vld_o(i2c_vld_i));

  initial forever #20 mclk_i = ~mclk_i;
  // Each write is accepted one cycle late, so the loader must hold it through a wait state.
  always @(negedge mclk_i) begin
    ack_w <= mem_we_o && !mem_ack_i && !ack_w;
    mem_ack_i <= ack_w;
  end
  always @(posedge mclk_i) begin
    if (mem_we_o && mem_ack_i && nwr < 16) begin
      wr[nwr] = {mem_sel_o, mem_addr_o, mem_wdata_o};
      nwr++;
    end
    if (fail_o) nfail++;
    if (i2c_stop_o) nstop++;
  end

  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic put(input int a, input logic [31:0] w, input bit add = 1'b1);
    for (int i = 0; i < 4; i++) u_ee.mem[a + i] = w[31 - 8 * i -: 8];
    if (add) sum += {32'h0, w};
  endtask
  // Footer kind: 0 true sum, 1 zero, 2 sum plus one.
  task automatic build(input logic [1:0] m0, input int foot);
    sum = 64'h0;
    put(0, 32'hAA00_0010);
    put(4, 32'h0002_0020);
    put(8, 32'h0027_0005);
    put(12, 32'hC0DE_0001);
    put(16, {1'b0, 13'h0000, m0, 16'h0100});
    put(20, 32'h0002_0ABC);
    put(24, 32'h1111_2222);
    put(28, 32'h3333_4444);
    put(32, 32'h8002_0040);
    put(36, 32'h0001_1234);
    put(40, 32'h5555_6666);
    sum = (foot == 1) ? 64'h0 : sum + ((foot == 2) ? 64'h1 : 64'h0);
    put(44, sum[63:32], 1'b0);
    put(48, sum[31:0], 1'b0);
  endtask
  task automatic run_boot(input logic i2c);
    use_i2c_i = i2c;
    nwr = 0;
    nfail = 0;
    nstop = 0;
    @(negedge mclk_i) boot_start_i = 1'b1;
    @(negedge mclk_i) boot_start_i = 1'b0;
    for (int n = 0; busy_o !== 1'b0; n++) begin
      if (n == 40000) begin
        chk("boot finish", 1, 0);
        wrap_up();
      end
      @(negedge mclk_i);
      if (n == 500 && busy_o) begin
        boot_start_i = 1'b1; // A start while busy must be ignored.
        @(negedge mclk_i) boot_start_i = 1'b0;
      end
    end
    // The last failure pulse stands in the cycle after busy falls; let it be counted.
    @(negedge mclk_i);
  endtask
  task automatic chk_writes(input logic [2:0] s0);
    chk("write count", nwr, 3);
    chk("word 0", wr[0], {s0, 16'h0100, 32'h1111_2222});
    chk("word 1", wr[1], {s0, 16'h0101, 32'h3333_4444});
    chk("word 2", wr[2], {3'h4, 16'h0040, 32'h5555_6666});
  endtask
  task automatic t_reset;
    chk("idle select", {spi_ss_b_o, spi_sclk_o, busy_o, mem_sel_o}, 6'h31);
    $display("test reset done");
  endtask
  task automatic t_i2c_good;
    build(2'h1, 0);
    run_boot(1'b1);
    chk_writes(3'h2);
    chk("done", {boot_done_o, panic_o}, 2'h2);
    chk("jump", jump_addr_o, 16'h1234);
    chk("pll", {pll_div_o, pll_feedback_divider_o, mclk_out_o}, 24'h0220_05);
    chk("speed", speed_cfg_o, 32'hC0DE_0001);
    chk("stop cycles", nstop, 4);
    $display("test i2c_good done");
  endtask
  task automatic t_spi_zero;
    build(2'h0, 1);
    run_boot(1'b0);
    chk_writes(3'h1);
    chk("done", {boot_done_o, panic_o, nfail[1:0]}, 4'h8);
    chk("jump", jump_addr_o, 16'h1234);
    $display("test spi_zero done");
  endtask
  task automatic t_panic(input logic [1:0] m0, input int foot, input logic [2:0] code,
    input logic i2c, input int poke = -1);
    build(m0, foot);
    if (poke >= 0) u_ee.mem[poke] = ~u_ee.mem[poke];
    run_boot(i2c);
    chk("attempts", nfail, 3);
    chk("select released", spi_ss_b_o, 1'b1);
    chk("panic", {boot_done_o, panic_o, sleep_o}, 3'h3);
    chk("panic code", panic_code_o, code);
    $display("test panic %0d done", code);
  endtask

  initial begin
    repeat (4) @(negedge mclk_i);
    rst_b_i = 1'b1;
    @(negedge mclk_i);
    t_reset();
    t_i2c_good();
    t_spi_zero();
    t_panic(2'h1, 2, 3'h5, 1'b1);
    t_panic(2'h3, 0, 3'h4, 1'b1);
    t_panic(2'h3, 0, 3'h4, 1'b0);
    t_panic(2'h0, 0, 3'h1, 1'b1, 0);
    t_panic(2'h0, 0, 3'h2, 1'b1, 4);
    t_panic(2'h0, 0, 3'h3, 1'b1, 9);
    wrap_up();
  end
endmodule // ebl_loader_tb_top
`default_nettype wire

// ===== verilog/ebl_consts.vh
// Constants for the boot image loader and its serial EEPROM reader.
`ifndef EBL_CONSTS_VH
`define EBL_CONSTS_VH

// Core clock and serial link timing.
`define EBL_CLK_KHZ        25000
`define EBL_SCLK_KHZ       1000
`define EBL_HALF_CYC       (`EBL_CLK_KHZ / (2 * `EBL_SCLK_KHZ))
`define EBL_SS_GAP_NS      100
`define EBL_SS_GAP_CYC     ((`EBL_SS_GAP_NS * (`EBL_CLK_KHZ / 1000) + 999) / 1000)

// Image layout.
`define EBL_SENTINEL       8'hAA
`define EBL_HDR_LAST       4'hF
`define EBL_DESC_LAST      4'h7
`define EBL_FOOT_LAST      4'h7
`define EBL_HDR_ADDR       24'h000000

// Link constants.
`define EBL_SPI_READ_CMD   8'h03
`define EBL_I2C_CHIP_ADDR  7'h50

// Target memory codes and one-hot selects.
`define EBL_MEM_DM0        2'h0
`define EBL_MEM_DM1        2'h1
`define EBL_MEM_PM         2'h2
`define EBL_SEL_DM0        3'h1
`define EBL_SEL_DM1        3'h2
`define EBL_SEL_PM         3'h4

// Boot attempts and failure codes.
`define EBL_MAX_ATTEMPTS   2'h3
`define EBL_PC_NONE        3'h0
`define EBL_PC_SENTINEL    3'h1
`define EBL_PC_HDR_ZERO    3'h2
`define EBL_PC_PLL_CHECK   3'h3
`define EBL_PC_MEM_SEL     3'h4
`define EBL_PC_CHECKSUM    3'h5

`endif

// ===== verilog/ebl_loader.v
// Boot image loader: parses header, data blocks and footer from a serial EEPROM.
//
// Functional notes
// - Header bytes 4,6,8,10 zero; 5,7,9,11 PLL settings; 12-15 speed config.
// - PLL check byte equals feedback divider plus clock output plus input divider.
// - Each block: eight-byte descriptor, then four-byte payload words.
// - Last-block flag set means footer follows; clear means another descriptor.
// - Memory code 0 selects data memory 0, 1 data memory 1, 2 program memory.
// - Payload writing starts at the descriptor's 16-bit base address.
// - Length counts 32-bit payload words; exactly that many are read and written.
// - Jump address is taken only from the block flagged last.
// - Footer is 64-bit sum of header, descriptors and data words, high half first.
// - After download, compare computed and footer checksums; mismatch raises panic.
// - A zero footer checksum disables the comparison.
// - Over I2C only chip address 0x50 is read.
// - Over SPI only the primary slave select is used.
// - Whole boot is tried three times; then software panic and sleep.
// - SPI reads use command 0x03 in mode 3.
`timescale 1ns/1ns
`default_nettype none
`include "ebl_consts.vh"

module ebl_loader (
  input  wire        mclk_i,          // Core clock, 25 MHz
  input  wire        rst_b_i,         // Synchronous reset, active low
  input  wire        boot_start_i,    // Start a self boot, one-cycle pulse
  input  wire        use_i2c_i,       // Boot over I2C when high, SPI when low
  output wire        spi_sclk_o,      // SPI clock
  output wire        spi_mosi_o,      // SPI data out
  output wire        spi_ss_b_o,      // SPI primary slave select, active low
  input  wire        spi_miso_i,      // SPI data in
  output wire        i2c_start_o,     // Open an I2C sequential read
  output wire        i2c_stop_o,      // Close the I2C read
  output wire [6:0]  i2c_chip_o,      // I2C chip address to read
  output wire [23:0] i2c_addr_o,      // I2C start byte address
  output wire        i2c_get_o,       // Request next I2C byte
  input  wire        i2c_rdy_i,       // I2C engine ready for a get
  input  wire [7:0]  i2c_byte_i,      // I2C received byte
  input  wire        i2c_vld_i,       // I2C byte valid pulse
  output wire        mem_we_o,        // Memory write request, held until ack
  output reg  [2:0]  mem_sel_o,       // One-hot target: PM, DM1, DM0
  output reg  [15:0] mem_addr_o,      // Memory word address
  output reg  [31:0] mem_wdata_o,     // Memory write data
  input  wire        mem_ack_i,       // Memory write accepted
  output reg  [7:0]  pll_div_o,       // PLL input divider
  output reg  [7:0]  pll_feedback_divider_o, // PLL feedback divider
  output reg  [7:0]  mclk_out_o,      // Master clock output setting
  output reg  [31:0] speed_cfg_o,     // EEPROM speed configuration
  output reg  [15:0] jump_addr_o,     // Program start address
  output wire        busy_o,          // Boot in progress
  output reg         boot_done_o,     // Image loaded, core may run
  output reg         fail_o,          // One attempt failed, pulse
  output reg  [2:0]  panic_code_o,    // Reason of the latest failure
  output reg         panic_o,         // Software panic after all attempts
  output reg         sleep_o          // Core held in sleep
);

  localparam [10:0] S_IDLE   = 11'h001;
  localparam [10:0] S_HSTART = 11'h002;
  localparam [10:0] S_HDR    = 11'h004;
  localparam [10:0] S_GAP    = 11'h008;
  localparam [10:0] S_BSTART = 11'h010;
  localparam [10:0] S_DESC   = 11'h020;
  localparam [10:0] S_DATA   = 11'h040;
  localparam [10:0] S_WR     = 11'h080;
  localparam [10:0] S_FOOT   = 11'h100;
  localparam [10:0] S_CHK    = 11'h200;
  localparam [10:0] S_FAIL   = 11'h400;

  reg [10:0] st_q;
  reg        i2c_q;
  reg        pend_q;
  reg [3:0]  bc_q;
  reg [31:0] wd_q;
  reg [23:0] fa_q;
  reg [7:0]  chk_q;
  reg        last_q;
  reg [15:0] left_q;
  reg [63:0] sum_q;
  reg [63:0] foot_q;
  reg [1:0]  att_q;
  reg        gap_hdr_q;

  wire        spi_rdy;
  wire [7:0]  spi_byte;
  wire        spi_vld;
  wire        src_rdy  = i2c_q ? i2c_rdy_i  : spi_rdy;
  wire        src_vld  = i2c_q ? i2c_vld_i  : spi_vld;
  wire [7:0]  src_byte = i2c_q ? i2c_byte_i : spi_byte;
  wire [31:0] wd_n     = {wd_q[23:0], src_byte};
  wire        fetch    = (st_q == S_HDR) || (st_q == S_DESC) || (st_q == S_DATA) ||
                         (st_q == S_FOOT);
  wire        get      = fetch && !pend_q && src_rdy;
  wire        start    = (st_q == S_HSTART) || (st_q == S_BSTART);
  // A failed attempt also releases the link, so a final panic never leaves the select low.
  wire        stop     = (st_q == S_GAP) || (st_q == S_CHK) || (st_q == S_FAIL);
  wire [23:0] rd_addr  = (st_q == S_HSTART) ? `EBL_HDR_ADDR : fa_q;
  wire        word_end = (bc_q[1:0] == 2'h3);

  assign busy_o      = (st_q != S_IDLE);
  assign mem_we_o    = (st_q == S_WR);
  assign i2c_chip_o  = `EBL_I2C_CHIP_ADDR;
  assign i2c_start_o = i2c_q && start;
  assign i2c_stop_o  = i2c_q && stop;
  assign i2c_addr_o  = rd_addr;
  assign i2c_get_o   = i2c_q && get;

  ebl_spi_rd u_spi (
    .mclk_i  (mclk_i),
    .rst_b_i (rst_b_i),
    .start_i (!i2c_q && start),
    .stop_i  (!i2c_q && stop),
    .addr_i  (rd_addr),
    .get_i   (!i2c_q && get),
    .miso_i  (spi_miso_i),
    .rdy_o   (spi_rdy),
    .byte_o  (spi_byte),
    .vld_o   (spi_vld),
    .sclk_o  (spi_sclk_o),
    .mosi_o  (spi_mosi_o),
    .ss_b_o  (spi_ss_b_o)
  );

  always @(posedge mclk_i) begin
    if (!rst_b_i) begin
      st_q        <= S_IDLE;
      i2c_q       <= 1'b0;
      pend_q      <= 1'b0;
      bc_q        <= 4'h0;
      wd_q        <= 32'h00000000;
      fa_q        <= 24'h000000;
      chk_q       <= 8'h00;
      last_q      <= 1'b0;
      left_q      <= 16'h0000;
      sum_q       <= 64'h0000000000000000;
      foot_q      <= 64'h0000000000000000;
      att_q       <= 2'h0;
      gap_hdr_q   <= 1'b0;
      mem_sel_o   <= `EBL_SEL_DM0;
      mem_addr_o  <= 16'h0000;
      mem_wdata_o <= 32'h00000000;
      pll_div_o   <= 8'h00;
      pll_feedback_divider_o <= 8'h00;
      mclk_out_o  <= 8'h00;
      speed_cfg_o <= 32'h00000000;
      jump_addr_o <= 16'h0000;
      boot_done_o <= 1'b0;
      fail_o      <= 1'b0;
      panic_code_o <= `EBL_PC_NONE;
      panic_o     <= 1'b0;
      sleep_o     <= 1'b0;
    end else begin
      fail_o <= 1'b0;
      if (get) begin
        pend_q <= 1'b1;
      end else if (src_vld) begin
        pend_q <= 1'b0;
      end
      if (fetch && src_vld) begin
        wd_q <= wd_n;
        bc_q <= bc_q + 4'h1;
        // Header, descriptors and payload all feed the running sum.
        if (word_end && (st_q != S_FOOT)) begin
          sum_q <= sum_q + {32'h00000000, wd_n};
        end
      end
      case (st_q)
        S_IDLE: begin
          if (boot_start_i) begin
            i2c_q       <= use_i2c_i;
            att_q       <= 2'h0;
            boot_done_o <= 1'b0;
            panic_o     <= 1'b0;
            sleep_o     <= 1'b0;
            panic_code_o <= `EBL_PC_NONE;
            st_q        <= S_HSTART;
          end
        end
        S_HSTART: begin
          sum_q  <= 64'h0000000000000000;
          bc_q   <= 4'h0;
          pend_q <= 1'b0;
          st_q   <= S_HDR;
        end
        S_HDR: begin
          if (src_vld) begin
            case (bc_q)
              4'h0: begin
                if (src_byte != `EBL_SENTINEL) begin
                  panic_code_o <= `EBL_PC_SENTINEL;
                  st_q <= S_FAIL;
                end
              end
              4'h1, 4'h2, 4'h3: fa_q <= {fa_q[15:0], src_byte};
              4'h4, 4'h6, 4'h8, 4'hA: begin
                if (src_byte != 8'h00) begin
                  panic_code_o <= `EBL_PC_HDR_ZERO;
                  st_q <= S_FAIL;
                end
              end
              4'h5: pll_div_o <= src_byte;
              4'h7: pll_feedback_divider_o <= src_byte;
              4'h9: chk_q <= src_byte;
              4'hB: begin
                mclk_out_o <= src_byte;
                if (chk_q != (pll_div_o + pll_feedback_divider_o + src_byte)) begin
                  panic_code_o <= `EBL_PC_PLL_CHECK;
                  st_q <= S_FAIL;
                end
              end
              default: begin
                speed_cfg_o <= {speed_cfg_o[23:0], src_byte};
                if (bc_q == `EBL_HDR_LAST) begin
                  gap_hdr_q <= 1'b0;
                  bc_q <= 4'h0;
                  st_q <= S_GAP;
                end
              end
            endcase
          end
        end
        S_GAP: begin
          // Select stays released long enough to end the previous read cleanly.
          bc_q <= bc_q + 4'h1;
          if (bc_q >= (`EBL_SS_GAP_CYC - 1)) begin
            bc_q <= 4'h0;
            st_q <= gap_hdr_q ? S_HSTART : S_BSTART;
          end
        end
        S_BSTART: begin
          bc_q <= 4'h0;
          st_q <= S_DESC;
        end
        S_DESC: begin
          if (src_vld) begin
            if (bc_q == 4'h3) begin
              last_q     <= wd_n[31];
              mem_addr_o <= wd_n[15:0];
              case (wd_n[17:16])
                `EBL_MEM_DM0: mem_sel_o <= `EBL_SEL_DM0;
                `EBL_MEM_DM1: mem_sel_o <= `EBL_SEL_DM1;
                `EBL_MEM_PM:  mem_sel_o <= `EBL_SEL_PM;
                default: begin
                  panic_code_o <= `EBL_PC_MEM_SEL;
                  st_q <= S_FAIL;
                end
              endcase
            end
            if (bc_q == `EBL_DESC_LAST) begin
              left_q <= wd_n[31:16];
              if (last_q) begin
                jump_addr_o <= wd_n[15:0];
              end
              bc_q <= 4'h0;
              if (wd_n[31:16] != 16'h0000) begin
                st_q <= S_DATA;
              end else begin
                st_q <= last_q ? S_FOOT : S_DESC;
              end
            end
          end
        end
        S_DATA: begin
          if (src_vld && word_end) begin
            mem_wdata_o <= wd_n;
            bc_q <= 4'h0;
            st_q <= S_WR;
          end
        end
        S_WR: begin
          // No byte is fetched here, so parsing waits on the memory.
          if (mem_ack_i) begin
            mem_addr_o <= mem_addr_o + 16'h0001;
            left_q <= left_q - 16'h0001;
            if (left_q == 16'h0001) begin
              st_q <= last_q ? S_FOOT : S_DESC;
            end else begin
              st_q <= S_DATA;
            end
          end
        end
        S_FOOT: begin
          if (src_vld) begin
            foot_q <= {foot_q[55:0], src_byte};
            if (bc_q == `EBL_FOOT_LAST) begin
              st_q <= S_CHK;
            end
          end
        end
        S_CHK: begin
          if ((foot_q == 64'h0000000000000000) || (foot_q == sum_q)) begin
            boot_done_o <= 1'b1;
            st_q <= S_IDLE;
          end else begin
            panic_code_o <= `EBL_PC_CHECKSUM;
            st_q <= S_FAIL;
          end
        end
        S_FAIL: begin
          fail_o <= 1'b1;
          bc_q <= 4'h0;
          if (att_q == (`EBL_MAX_ATTEMPTS - 2'h1)) begin
            panic_o <= 1'b1;
            sleep_o <= 1'b1;
            gap_hdr_q <= 1'b0;
            st_q <= S_IDLE;
          end else begin
            att_q <= att_q + 2'h1;
            gap_hdr_q <= 1'b1;
            st_q <= S_GAP;
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end

endmodule // ebl_loader

`default_nettype wire

// ===== verilog/ebl_spi_rd.v
// SPI mode 3 sequential-read engine for the boot EEPROM.
`timescale 1ns/1ns
`default_nettype none
`include "ebl_consts.vh"

module ebl_spi_rd (
  input  wire        mclk_i,   // Core clock
  input  wire        rst_b_i,  // Synchronous reset, active low
  input  wire        start_i,  // Open a read at addr_i
  input  wire        stop_i,   // Deselect and abort
  input  wire [23:0] addr_i,   // Start byte address
  input  wire        get_i,    // Fetch the next byte
  input  wire        miso_i,   // Serial data in
  output wire        rdy_o,    // Ready for a get
  output reg  [7:0]  byte_o,   // Received byte
  output reg         vld_o,    // Byte valid pulse
  output reg         sclk_o,   // Serial clock, idles high
  output reg         mosi_o,   // Serial data out
  output reg         ss_b_o    // Primary slave select, active low
);

  reg [31:0] sh_q;
  reg [5:0]  n_q;
  reg        act_q;
  reg        txm_q;
  reg [7:0]  rx_q;
  reg [4:0]  dv_q;

  assign rdy_o = !ss_b_o && !act_q;

  always @(posedge mclk_i) begin
    if (!rst_b_i) begin
      sh_q   <= 32'h00000000;
      n_q    <= 6'h00;
      act_q  <= 1'b0;
      txm_q  <= 1'b0;
      rx_q   <= 8'h00;
      dv_q   <= 5'h00;
      byte_o <= 8'h00;
      vld_o  <= 1'b0;
      sclk_o <= 1'b1;
      mosi_o <= 1'b0;
      ss_b_o <= 1'b1;
    end else begin
      vld_o <= 1'b0;
      if (stop_i) begin
        ss_b_o <= 1'b1;
        act_q  <= 1'b0;
        sclk_o <= 1'b1;
        dv_q   <= 5'h00;
      end else if (start_i) begin
        // Command and address go out once, then bytes stream on request.
        ss_b_o <= 1'b0;
        sh_q   <= {`EBL_SPI_READ_CMD, addr_i};
        n_q    <= 6'h20;
        act_q  <= 1'b1;
        txm_q  <= 1'b1;
        dv_q   <= 5'h00;
      end else if (get_i && rdy_o) begin
        n_q   <= 6'h08;
        act_q <= 1'b1;
        txm_q <= 1'b0;
        dv_q  <= 5'h00;
      end else if (act_q) begin
        if (dv_q == (`EBL_HALF_CYC - 1)) begin
          dv_q <= 5'h00;
          if (sclk_o) begin
            // Mode 3: drive on the falling edge, sample on the rising edge.
            sclk_o <= 1'b0;
            mosi_o <= sh_q[31];
            sh_q   <= {sh_q[30:0], 1'b0};
          end else begin
            sclk_o <= 1'b1;
            rx_q   <= {rx_q[6:0], miso_i};
            n_q    <= n_q - 6'h01;
            if (n_q == 6'h01) begin
              act_q <= 1'b0;
              if (!txm_q) begin
                byte_o <= {rx_q[6:0], miso_i};
                vld_o  <= 1'b1;
              end
            end
          end
        end else begin
          dv_q <= dv_q + 5'h01;
        end
      end
    end
  end

endmodule // ebl_spi_rd

`default_nettype wire
